/* File: logic/codec_power_consts.svh */
// Register indices, field positions, reset values and bus codes of the codec power control block
`ifndef CODEC_POWER_CONSTS_SVH
`define CODEC_POWER_CONSTS_SVH

// Register indices; the byte address is four times the index
`define IDX_SOFT_RESET    10'h001
`define IDX_HP_DRIVER     10'h01F
`define IDX_SPK_DRIVER    10'h020
`define IDX_BLOCK_POWER   10'h040
`define IDX_STAGE_STATUS  10'h041
`define IDX_IRQ_STATUS    10'h042
`define IDX_IRQ_CLEAR     10'h043
`define IDX_IRQ_ENABLE    10'h044

// Field positions
`define BIT_SOFT_RESET    0
`define BIT_STAGE_RESET   7
`define BIT_PWR_HP        0
`define BIT_PWR_SPK       1
`define STAGE_HP          0
`define STAGE_SPK         1
`define NUM_STAGES        2

// Driver register bits kept in storage; the stage reset bit is an action
`define DRV_STORE_MASK    8'h7F

// Reset values
`define RST_HP_DRIVER     8'h00
`define RST_SPK_DRIVER    8'h00
`define RST_BLOCK_POWER   8'h00
`define RST_IRQ_ENABLE    2'h0
`define RST_IRQ_STATUS    2'h0

// AXI response codes
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

/* File: logic/codec_power_pkg.sv */
// Types shared by the codec power control block
`default_nettype none
`include "codec_power_consts.svh"

package codec_power_pkg;

	typedef enum logic [0:0] {
		WR_IDLE = 1'b0,
		WR_RESP = 1'b1
	} wr_state_t;

	typedef enum logic [0:0] {
		RD_IDLE = 1'b0,
		RD_DATA = 1'b1
	} rd_state_t;

	typedef struct packed {
		wr_state_t              wst;
		logic                   aw_got;
		logic                   w_got;
		logic [9:0]             waddr;
		logic [7:0]             wdata;
		logic                   wlane;
		logic [1:0]             bresp;
		rd_state_t              rst;
		logic [7:0]             rdata;
		logic [1:0]             rresp;
		logic [7:0]             hp_ctrl;
		logic [7:0]             spk_ctrl;
		logic [7:0]             block_pwr;
		logic [`NUM_STAGES-1:0] irq_en;
		logic [`NUM_STAGES-1:0] irq_stat;
		logic [`NUM_STAGES-1:0] stage_rst;
		logic                   soft_rst;
	} ctrl_state_t;

	typedef struct packed {
		logic tripped;
		logic stage_on;
		logic trip_event;
	} stage_state_t;

endpackage

`default_nettype wire

/* File: logic/codec_power_stage_control.sv */
// Codec power control: block power enables, output stage fault latches and AXI4-Lite registers
//
// Operation
// - A latched overcurrent shutdown is recovered by a reset of that stage alone.
// - Stage reset re-enables the stage; every other register keeps its value.
// - Headphone and speaker stages have separate reset bits.
// - Bit 7 of driver register 31 resets the headphone stage.
// - Bit 7 of driver register 32 resets both speaker outputs.
// - After hardware or software reset every block is powered down.
// - Each block's power is set individually by a register write.
// - Powering a block down changes no register; contents persist.
// - Registers are 8 bits wide; stored bits read back (driver bits 6:0, IRQ enable bits 1:0); soft reset and IRQ clear read 0.
`timescale 1ns/10ps
`default_nettype none

`include "codec_power_consts.svh"

module codec_power_stage_control
	import codec_power_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [11:0] awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	// AXI4-Lite write data
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read address
	input  wire logic [11:0] araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	// AXI4-Lite read data
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Overcurrent detectors of the output stages
	input  wire logic        hp_overcurrent,
	input  wire logic        spk_overcurrent,
	// Power enables
	output logic             headphone_output_en,
	output logic             speaker_out_positive_en,
	output logic             speaker_out_negative_en,
	output logic [7:0]       block_power_en,
	// Interrupt
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	ctrl_state_t            st_r;
	ctrl_state_t            st_nxt;

	logic [`NUM_STAGES-1:0] oc_in;
	logic [`NUM_STAGES-1:0] stage_pwr;
	logic [`NUM_STAGES-1:0] stage_trip;
	logic [`NUM_STAGES-1:0] stage_on;
	logic [`NUM_STAGES-1:0] trip_ev;

	logic                   aw_take;
	logic                   w_take;
	logic                   do_wr;
	logic [9:0]             wr_idx;
	logic [7:0]             wr_val;
	logic                   wr_lane;
	logic [`NUM_STAGES-1:0] clr_mask;
	logic                   wr_ok;
	logic [8:0]             rd_word;

	////////////////////////////////////////////////////////////////////////////////
	// Read mux: bit 8 flags a mapped address

	function automatic logic [8:0] read_reg(
		input logic [9:0]             idx,
		input ctrl_state_t            s,
		input logic [`NUM_STAGES-1:0] trip,
		input logic [`NUM_STAGES-1:0] on
	);
		logic [8:0] r;
		r = 9'h000;
		case (idx)
			`IDX_SOFT_RESET:   r = 9'h100;
			`IDX_HP_DRIVER:    r = {1'b1, s.hp_ctrl & `DRV_STORE_MASK};
			`IDX_SPK_DRIVER:   r = {1'b1, s.spk_ctrl & `DRV_STORE_MASK};
			`IDX_BLOCK_POWER:  r = {1'b1, s.block_pwr};
			`IDX_STAGE_STATUS: r = {1'b1, 4'h0, on, trip};
			`IDX_IRQ_STATUS:   r = {1'b1, 6'h00, s.irq_stat};
			`IDX_IRQ_CLEAR:    r = 9'h100;
			`IDX_IRQ_ENABLE:   r = {1'b1, 6'h00, s.irq_en};
			default:           r = 9'h000;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	assign awready = (st_r.wst == WR_IDLE) && !st_r.aw_got;
	assign wready  = (st_r.wst == WR_IDLE) && !st_r.w_got;
	assign arready = (st_r.rst == RD_IDLE);

	always_comb begin
		st_nxt    = st_r;
		aw_take   = awvalid && awready;
		w_take    = wvalid && wready;
		do_wr     = 1'b0;
		wr_idx    = st_r.aw_got ? st_r.waddr : awaddr[11:2];
		wr_val    = st_r.w_got ? st_r.wdata : wdata[7:0];
		wr_lane   = st_r.w_got ? st_r.wlane : wstrb[0];
		clr_mask  = '0;
		wr_ok     = 1'b1;
		rd_word   = 9'h000;

		// Action bits live for one cycle only
		st_nxt.stage_rst = '0;
		st_nxt.soft_rst  = 1'b0;

		// Write channel: address and data may arrive in either order
		case (st_r.wst)
			WR_IDLE: begin
				if (aw_take) begin
					st_nxt.aw_got = 1'b1;
					st_nxt.waddr  = awaddr[11:2];
				end
				if (w_take) begin
					st_nxt.w_got = 1'b1;
					st_nxt.wdata = wdata[7:0];
					st_nxt.wlane = wstrb[0];
				end
				do_wr = (st_r.aw_got || aw_take) && (st_r.w_got || w_take);
				if (do_wr) begin
					st_nxt.aw_got = 1'b0;
					st_nxt.w_got  = 1'b0;
					st_nxt.wst    = WR_RESP;
				end
			end
			WR_RESP: begin
				if (bready) begin
					st_nxt.wst = WR_IDLE;
				end
			end
			default: begin
				st_nxt.wst = WR_IDLE;
			end
		endcase

		// Register effects of a write; only byte lane 0 carries data
		if (do_wr) begin
			case (wr_idx)
				`IDX_SOFT_RESET: begin
					if (wr_lane && wr_val[`BIT_SOFT_RESET]) begin
						// Back to defaults; all blocks end up powered down
						st_nxt.soft_rst  = 1'b1;
						st_nxt.hp_ctrl   = `RST_HP_DRIVER;
						st_nxt.spk_ctrl  = `RST_SPK_DRIVER;
						st_nxt.block_pwr = `RST_BLOCK_POWER;
						st_nxt.irq_en    = `RST_IRQ_ENABLE;
						clr_mask         = '1;
					end
				end
				`IDX_HP_DRIVER: begin
					if (wr_lane) begin
						st_nxt.hp_ctrl = wr_val & `DRV_STORE_MASK;
						// Only the headphone stage is touched
						st_nxt.stage_rst[`STAGE_HP] = wr_val[`BIT_STAGE_RESET];
					end
				end
				`IDX_SPK_DRIVER: begin
					if (wr_lane) begin
						st_nxt.spk_ctrl = wr_val & `DRV_STORE_MASK;
						st_nxt.stage_rst[`STAGE_SPK] = wr_val[`BIT_STAGE_RESET];
					end
				end
				`IDX_BLOCK_POWER: begin
					if (wr_lane) begin
						// One bit per block; other registers are left alone
						st_nxt.block_pwr = wr_val;
					end
				end
				`IDX_IRQ_CLEAR: begin
					if (wr_lane) begin
						clr_mask = wr_val[`NUM_STAGES-1:0];
					end
				end
				`IDX_IRQ_ENABLE: begin
					if (wr_lane) begin
						st_nxt.irq_en = wr_val[`NUM_STAGES-1:0];
					end
				end
				`IDX_STAGE_STATUS,
				`IDX_IRQ_STATUS: begin
					// Read-only; the write is accepted and dropped
					wr_ok = 1'b1;
				end
				default: begin
					wr_ok = 1'b0;
				end
			endcase
			st_nxt.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end

		// Sticky trip events; a new trip beats a clear in the same cycle
		st_nxt.irq_stat = (st_r.irq_stat & ~clr_mask) | trip_ev;

		// Read channel
		case (st_r.rst)
			RD_IDLE: begin
				if (arvalid) begin
					rd_word      = read_reg(araddr[11:2], st_r, stage_trip, stage_on);
					st_nxt.rdata = rd_word[7:0];
					st_nxt.rresp = rd_word[8] ? `RESP_OKAY : `RESP_SLVERR;
					st_nxt.rst   = RD_DATA;
				end
			end
			RD_DATA: begin
				if (rready) begin
					st_nxt.rst = RD_IDLE;
				end
			end
			default: begin
				st_nxt.rst = RD_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// All fields reset to zero: idle bus, blocks off, no events
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output stage latches

	assign oc_in[`STAGE_HP]      = hp_overcurrent;
	assign oc_in[`STAGE_SPK]     = spk_overcurrent;
	assign stage_pwr[`STAGE_HP]  = st_r.block_pwr[`BIT_PWR_HP];
	assign stage_pwr[`STAGE_SPK] = st_r.block_pwr[`BIT_PWR_SPK];

	// Each stage has its own latch so one can be recovered while the other stays off
	generate
		for (genvar i = 0; i < `NUM_STAGES; i++) begin : g_stage
			power_stage_latch u_latch (
				.aclk         (aclk),
				.aresetn      (aresetn),
				.soft_reset   (st_r.soft_rst),
				.stage_reset  (st_r.stage_rst[i]),
				.power_enable (stage_pwr[i]),
				.overcurrent  (oc_in[i]),
				.tripped      (stage_trip[i]),
				.stage_on     (stage_on[i]),
				.trip_event   (trip_ev[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign bvalid = (st_r.wst == WR_RESP);
	assign bresp  = st_r.bresp;
	assign rvalid = (st_r.rst == RD_DATA);
	assign rdata  = {24'h000000, st_r.rdata};
	assign rresp  = st_r.rresp;

	assign headphone_output_en     = stage_on[`STAGE_HP];
	// Both halves of the bridge share one latch and switch together
	assign speaker_out_positive_en = stage_on[`STAGE_SPK];
	assign speaker_out_negative_en = stage_on[`STAGE_SPK];
	assign block_power_en          = st_r.block_pwr;

	assign irq = |(st_r.irq_stat & st_r.irq_en);

endmodule // codec_power_stage_control

`default_nettype wire

/* File: logic/power_stage_latch.sv */
// Overcurrent shutdown latch and enable for one output power stage
`timescale 1ns/10ps
`default_nettype none

module power_stage_latch
	import codec_power_pkg::*;
(
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Control
	input  wire logic soft_reset,
	input  wire logic stage_reset,
	input  wire logic power_enable,
	// Analog fault input
	input  wire logic overcurrent,
	// State
	output logic      tripped,
	output logic      stage_on,
	output logic      trip_event
);

	stage_state_t st_r;
	stage_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		// A fault in the clearing cycle keeps the latch set
		if (overcurrent) begin
			st_nxt.tripped = 1'b1;
		end else if (stage_reset || soft_reset) begin
			st_nxt.tripped = 1'b0;
		end
		st_nxt.trip_event = overcurrent && !st_r.tripped;
		// Enable setting is ignored while latched off
		st_nxt.stage_on = power_enable && !st_nxt.tripped;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tripped    = st_r.tripped;
	assign stage_on   = st_r.stage_on;
	assign trip_event = st_r.trip_event;

endmodule // power_stage_latch

`default_nettype wire

/* File: testbench/codec_power_chk.sv */
// Port checker of the codec power control block
`timescale 1ns/10ps
`default_nettype none

module codec_power_chk (
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Bus handshakes
	input wire logic       awready,
	input wire logic       wready,
	input wire logic       bvalid,
	input wire logic       bready,
	input wire logic       rvalid,
	input wire logic       rready,
	// Stages
	input wire logic       hp_overcurrent,
	input wire logic       spk_overcurrent,
	input wire logic       headphone_output_en,
	input wire logic       speaker_out_positive_en,
	input wire logic       speaker_out_negative_en,
	input wire logic [7:0] block_power_en,
	input wire logic       irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_hp_trip_off: assert property (hp_overcurrent |=> !headphone_output_en)
		else $error("headphone stage on after fault");
	a_spk_trip_off: assert property (spk_overcurrent |=> !speaker_out_positive_en)
		else $error("speaker stage on after fault");
	a_spk_pair_same: assert property (speaker_out_positive_en == speaker_out_negative_en)
		else $error("speaker outputs differ");
	a_hp_needs_power: assert property (headphone_output_en |-> $past(block_power_en[0]))
		else $error("headphone stage on without power bit");
	a_spk_needs_power: assert property (speaker_out_positive_en |-> $past(block_power_en[1]))
		else $error("speaker stage on without power bit");
	a_resp_holds: assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped");
	a_read_holds: assert property (rvalid && !rready |=> rvalid)
		else $error("read data dropped");
	a_busy_refuse: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while response pending");

	c_hp_trip: cover property ($rose(hp_overcurrent) ##1 $fell(headphone_output_en));
	c_spk_trip: cover property (spk_overcurrent ##1 !speaker_out_negative_en);
	c_irq: cover property ($rose(irq));
endmodule // codec_power_chk

bind codec_power_stage_control codec_power_chk chk_u (.*);

`default_nettype wire

/* File: testbench/tb_codec_power_stage_control.sv */
// Self-checking bench of the codec power control block
`timescale 1ns/10ps
`default_nettype none
`include "codec_power_consts.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module tb_codec_power_stage_control;
	import codec_power_pkg::*;
	logic        aclk = 0, aresetn = 0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'hF;
	logic [2:0]  awprot = 3'h0, arprot = 3'h0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        hp_overcurrent = 0, spk_overcurrent = 0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp;
	logic        headphone_output_en, speaker_out_positive_en, speaker_out_negative_en;
	logic [7:0]  block_power_en;
	int          n_mismatch = 0, comparisons = 0;

	codec_power_stage_control dut_u (.*);

	initial forever #10 aclk = ~aclk;

	task finish_test;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask

	task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] e = `RESP_OKAY,
			input logic [3:0] s = 4'hF);
		logic a, w;
		a = 1;
		w = 1;
		@(posedge aclk);
		awaddr <= {i, 2'b00};
		wdata <= {24'h0, d};
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		// Each channel is released on its own ready
		while (a || w) begin
			@(posedge aclk);
			if (a && awready) begin a = 0; awvalid <= 0; end
			if (w && wready) begin w = 0; wvalid <= 0; end
		end
		bready <= 1;
		do @(posedge aclk); while (bvalid !== 1);
		bready <= 0;
		`CHK(bresp, e)
	endtask

	task automatic rd(input logic [9:0] i, input logic [7:0] d, input logic [1:0] e = `RESP_OKAY);
		@(posedge aclk);
		araddr <= {i, 2'b00};
		arvalid <= 1;
		do @(posedge aclk); while (arready !== 1);
		arvalid <= 0;
		rready <= 1;
		do @(posedge aclk); while (rvalid !== 1);
		rready <= 0;
		`CHK(rdata, {24'h0, d})
		`CHK(rresp, e)
	endtask

	task automatic en(input logic [2:0] x);
		`CHK({headphone_output_en, speaker_out_positive_en, speaker_out_negative_en}, x)
	endtask

	// One cycle of fault, then long enough for the sticky status to land
	task automatic oc(input logic h, input logic s);
		@(posedge aclk);
		hp_overcurrent <= h;
		spk_overcurrent <= s;
		@(posedge aclk);
		hp_overcurrent <= 0;
		spk_overcurrent <= 0;
		tick(2);
	endtask

	task t_reset;
		tick(1);
		en(3'b000);
		`CHK(block_power_en, 8'h00)
		`CHK(irq, 1'b0)
		rd(`IDX_HP_DRIVER, 8'h00);
		rd(`IDX_IRQ_ENABLE, 8'h00);
	endtask

	task t_power;
		wr(`IDX_BLOCK_POWER, 8'h03);
		tick(1);
		en(3'b111);
		wr(`IDX_BLOCK_POWER, 8'h01);
		tick(1);
		en(3'b100);
		wr(`IDX_HP_DRIVER, 8'h55);
		wr(`IDX_SPK_DRIVER, 8'h2A);
		wr(`IDX_BLOCK_POWER, 8'hFC);
		tick(1);
		en(3'b000);
		`CHK(block_power_en, 8'hFC)
		rd(`IDX_HP_DRIVER, 8'h55);
		rd(`IDX_SPK_DRIVER, 8'h2A);
		// A write without lane 0 and a write to a read-only register change nothing
		wr(`IDX_HP_DRIVER, 8'h11, `RESP_OKAY, 4'h0);
		rd(`IDX_HP_DRIVER, 8'h55);
		wr(`IDX_STAGE_STATUS, 8'hFF);
		rd(`IDX_STAGE_STATUS, 8'h00);
		rd(`IDX_IRQ_CLEAR, 8'h00);
		rd(10'h3FF, 8'h00, `RESP_SLVERR);
		wr(10'h3FF, 8'h11, `RESP_SLVERR);
	endtask

	task t_trip;
		wr(`IDX_BLOCK_POWER, 8'h03);
		wr(`IDX_IRQ_ENABLE, 8'h01);
		oc(1, 0);
		en(3'b011);
		`CHK(irq, 1'b1)
		rd(`IDX_STAGE_STATUS, 8'h09);
		wr(`IDX_BLOCK_POWER, 8'h03);
		tick(1);
		en(3'b011);
		wr(`IDX_HP_DRIVER, 8'hD5);
		tick(1);
		en(3'b111);
		rd(`IDX_HP_DRIVER, 8'h55);
		rd(`IDX_IRQ_ENABLE, 8'h01);
		wr(`IDX_IRQ_CLEAR, 8'h01);
		tick(1);
		`CHK(irq, 1'b0)
		oc(0, 1);
		en(3'b100);
		`CHK(irq, 1'b0)
		rd(`IDX_IRQ_STATUS, 8'h02);
		wr(`IDX_HP_DRIVER, 8'h80);
		tick(1);
		en(3'b100);
		wr(`IDX_SPK_DRIVER, 8'hAA);
		tick(1);
		en(3'b111);
		rd(`IDX_SPK_DRIVER, 8'h2A);
	endtask

	task t_soft;
		// Both stages latched off, so the soft reset must clear the latches as well
		oc(1, 1);
		en(3'b000);
		`CHK(irq, 1'b1)
		wr(`IDX_SOFT_RESET, 8'h01);
		tick(1);
		en(3'b000);
		`CHK(block_power_en, 8'h00)
		`CHK(irq, 1'b0)
		rd(`IDX_SPK_DRIVER, 8'h00);
		rd(`IDX_IRQ_STATUS, 8'h00);
		rd(`IDX_STAGE_STATUS, 8'h00);
		wr(`IDX_BLOCK_POWER, 8'h03);
		tick(1);
		en(3'b111);
	endtask

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		t_reset;
		t_power;
		t_trip;
		t_soft;
		finish_test;
	end

	// Whole run is about 130 cycles
	initial begin
		#200000;
		n_mismatch++;
		finish_test;
	end
endmodule // tb_codec_power_stage_control

`default_nettype wire
